// [hdl/push_pull_pwm_gate_logic.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pwm_gate_defines.svh"
// Operation
// - Pulse train low holds both gates off
// - Each rising edge while ready starts new period
// - Pulse high time bounds duty cycle
// - Ignore pulses until reference and supplies good
// - Overcurrent ends pulse, sets flag
// - Flag high until reference and supplies are good
// - Controller waits for flag low first
// - Controller soft starts duty, fixed frequency
// - Controller chooses current limit response
// - Gates alternate periods, never both on
// - Flag clears on edge after clean pulse
module push_pull_pwm_gate_logic
	import pwm_gate_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	pwm_gate_if.device link,
	input wire logic ref_good,
	input wire logic supplies_good,
	input wire logic pwm_trip,
	input wire logic limit_trip,
	output logic [1:0] gate_drive_output
);
	logic [2:0] pt_sync_reg;
	logic [2:0] pwm_sync_reg;
	logic [2:0] lim_sync_reg;
	logic pt_reg;
	logic pwm_reg;
	logic lim_reg;
	logic ready_reg;
	logic phase_reg;
	logic active_reg;
	logic clean_reg;
	logic flag_reg;
	logic first_ready_reg;
	logic pt_rise;
	logic pt_now;
	logic pwm_now;
	logic lim_now;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pt_sync_reg <= 3'h0;
			pwm_sync_reg <= 3'h0;
			lim_sync_reg <= 3'h0;
		end else begin
			pt_sync_reg <= {pt_sync_reg[1:0], link.pulse_train};
			pwm_sync_reg <= {pwm_sync_reg[1:0], pwm_trip};
			lim_sync_reg <= {lim_sync_reg[1:0], limit_trip};
		end
	end

	// Filtered levels: change once stages two and three agree
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pt_reg <= 1'b0;
			pwm_reg <= 1'b0;
			lim_reg <= 1'b0;
		end else begin
			if (pt_sync_reg[1] == pt_sync_reg[2])
				pt_reg <= pt_sync_reg[2];
			if (pwm_sync_reg[1] == pwm_sync_reg[2])
				pwm_reg <= pwm_sync_reg[2];
			if (lim_sync_reg[1] == lim_sync_reg[2])
				lim_reg <= lim_sync_reg[2];
		end
	end

	assign pt_now = (pt_sync_reg[1] == pt_sync_reg[2]) ? pt_sync_reg[2] : pt_reg;
	assign pwm_now = (pwm_sync_reg[1] == pwm_sync_reg[2]) ? pwm_sync_reg[2] : pwm_reg;
	assign lim_now = (lim_sync_reg[1] == lim_sync_reg[2]) ? lim_sync_reg[2] : lim_reg;
	assign pt_rise = pt_now && !pt_reg && ready_reg;

	// Ready once reference and supplies are good
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			ready_reg <= 1'b0;
		else
			ready_reg <= ref_good && supplies_good;
	end

	// Period start, phase toggle and pulse termination
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			active_reg <= 1'b0;
			phase_reg <= 1'b0;
		end else if (!ready_reg) begin
			active_reg <= 1'b0;
		end else if (pt_rise) begin
			active_reg <= !lim_now && !pwm_now;
			phase_reg <= !phase_reg;
		end else if (!pt_now || pwm_now || lim_now) begin
			active_reg <= 1'b0;
		end
	end

	// Gate steering, gated by pulse level and trips combinationally
	always_comb begin
		gate_drive_output = 2'h0;
		if (active_reg && pt_now && !pwm_now && !lim_now && ready_reg) begin
			if (phase_reg)
				gate_drive_output = 2'h1;
			else
				gate_drive_output = 2'h2;
		end
	end

	// Period was clean: a gate was on and limit never tripped
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			clean_reg <= 1'b0;
		else if (pt_rise)
			clean_reg <= 1'b0;
		else if (lim_now)
			clean_reg <= 1'b0;
		else if (gate_drive_output != 2'h0)
			clean_reg <= 1'b1;
	end

	// Flag: set wins over clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			flag_reg <= 1'b1;
		else if (!ready_reg)
			flag_reg <= 1'b1;
		else if (lim_now && active_reg)
			flag_reg <= 1'b1;
		else if (pt_rise && clean_reg)
			flag_reg <= 1'b0;
		else if (flag_reg && !clean_reg && !active_reg && !pt_now && first_ready_reg)
			flag_reg <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			first_ready_reg <= 1'b1;
		else if (!ready_reg)
			first_ready_reg <= 1'b1;
		else if (flag_reg && first_ready_reg)
			first_ready_reg <= 1'b0;
	end

	assign link.current_limit_flag = flag_reg;
endmodule : push_pull_pwm_gate_logic
`default_nettype wire

// [hdl/pwm_gate_defines.svh]
`ifndef PWM_GATE_DEFINES_SVH
`define PWM_GATE_DEFINES_SVH

// Controller side defaults
`define PERIOD_CYCLES_DEF 16'h0100
`define DUTY_MAX_DEF 16'h0080
`define SOFT_STEP_DEF 16'h0001
`define FLAG_LIMIT_DEF 8'h03
`define HICCUP_CYCLES_DEF 16'h1000

`endif

// [hdl/pwm_gate_pkg.sv]
package pwm_gate_pkg;
	typedef enum logic [1:0] {
		CTL_WAIT_READY = 2'b00,
		CTL_RUN = 2'b01,
		CTL_HICCUP = 2'b10,
		CTL_LATCHED = 2'b11
	} ctl_state_t;
endpackage : pwm_gate_pkg

// [hdl/pwm_gate_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface pwm_gate_if;
	logic pulse_train;
	logic current_limit_flag;
	modport device (input pulse_train, output current_limit_flag);
	modport controller (output pulse_train, input current_limit_flag);
endinterface : pwm_gate_if
`default_nettype wire

// [hdl/pwm_pulse_controller.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pwm_gate_defines.svh"
module pwm_pulse_controller
	import pwm_gate_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	pwm_gate_if.controller link,
	input wire logic run_enable,
	input wire logic [15:0] period_cycles,
	input wire logic [15:0] duty_limit,
	input wire logic [1:0] limit_policy,
	output logic [7:0] limit_events,
	output logic running
);
	logic [2:0] flag_sync_reg;
	logic flag_reg;
	logic flag_rise;
	ctl_state_t state_reg;
	logic [15:0] count_reg;
	logic [15:0] duty_reg;
	logic [15:0] hold_reg;
	logic [7:0] events_reg;
	logic pulse_reg;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			flag_sync_reg <= 3'h7;
		else
			flag_sync_reg <= {flag_sync_reg[1:0], link.current_limit_flag};
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			flag_reg <= 1'b1;
		else if (flag_sync_reg[1] == flag_sync_reg[2])
			flag_reg <= flag_sync_reg[2];
	end

	assign flag_rise = (flag_sync_reg[1] == flag_sync_reg[2]) && flag_sync_reg[2] && !flag_reg;

	// Period counter, soft-start duty and policy
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= CTL_WAIT_READY;
			count_reg <= 16'h0000;
			duty_reg <= 16'h0000;
			hold_reg <= 16'h0000;
			events_reg <= 8'h00;
			pulse_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				CTL_WAIT_READY: begin
					pulse_reg <= 1'b0;
					duty_reg <= 16'h0000;
					count_reg <= 16'h0000;
					if (!flag_reg && run_enable)
						state_reg <= CTL_RUN;
				end
				CTL_RUN: begin
					if (!run_enable) begin
						state_reg <= CTL_WAIT_READY;
						pulse_reg <= 1'b0;
					end else if (flag_rise) begin
						events_reg <= events_reg + 8'h01;
						pulse_reg <= 1'b0;
						if (limit_policy == 2'h0)
							state_reg <= CTL_LATCHED;
						else if (limit_policy == 2'h1 || events_reg >= `FLAG_LIMIT_DEF) begin
							state_reg <= CTL_HICCUP;
							hold_reg <= `HICCUP_CYCLES_DEF;
						end
					end else begin
						if (count_reg + 16'h0001 >= period_cycles) begin
							count_reg <= 16'h0000;
							if (duty_reg < duty_limit)
								duty_reg <= duty_reg + `SOFT_STEP_DEF;
						end else begin
							count_reg <= count_reg + 16'h0001;
						end
						pulse_reg <= (count_reg + 16'h0001 < duty_reg) || (count_reg + 16'h0001 >= period_cycles && duty_reg != 16'h0000);
					end
				end
				CTL_HICCUP: begin
					pulse_reg <= 1'b0;
					if (hold_reg == 16'h0000) begin
						events_reg <= 8'h00;
						state_reg <= CTL_WAIT_READY;
					end else begin
						hold_reg <= hold_reg - 16'h0001;
					end
				end
				CTL_LATCHED: begin
					pulse_reg <= 1'b0;
					if (!run_enable) begin
						events_reg <= 8'h00;
						state_reg <= CTL_WAIT_READY;
					end
				end
			endcase
		end
	end

	assign link.pulse_train = pulse_reg;
	assign limit_events = events_reg;
	assign running = (state_reg == CTL_RUN);
endmodule : pwm_pulse_controller
`default_nettype wire

// [tb/pwm_gate_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module pwm_gate_sva (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic pulse_train,
	input wire logic current_limit_flag,
	input wire logic ref_good,
	input wire logic supplies_good,
	input wire logic pwm_trip,
	input wire logic limit_trip,
	input wire logic [1:0] gate_drive_output
);
	logic [1:0] last_reg;
	logic [1:0] rises_reg;
	logic pt_q_reg;
	logic on_q_reg;
	wire logic on = |gate_drive_output;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_idle_low;
		(!pulse_train) [*5];
	endsequence
	sequence s_not_ready;
		(!(ref_good && supplies_good)) [*8];
	endsequence
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			last_reg <= 2'h0;
		else if (on)
			last_reg <= gate_drive_output;
	end
	// Pin rises since the last gate pulse began
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rises_reg <= 2'h0;
			pt_q_reg <= 1'b0;
			on_q_reg <= 1'b0;
		end else begin
			pt_q_reg <= pulse_train;
			on_q_reg <= on;
			if (on && !on_q_reg)
				rises_reg <= {1'b0, pulse_train && !pt_q_reg};
			else if (pulse_train && !pt_q_reg && rises_reg != 2'h3)
				rises_reg <= rises_reg + 2'h1;
		end
	end
	a_never_both: assert property (!(&gate_drive_output)) else $error("both gates on");
	a_gate_alternates: assert property ($rose(on) && |last_reg && rises_reg == 2'h1 |-> gate_drive_output == ~last_reg)
		else $error("gate phase repeated");
	a_idle_low_off: assert property (s_idle_low |-> !on) else $error("gate on while low");
	a_fall_ends: assert property ($fell(pulse_train) |-> ##[0:3] !on) else $error("late off");
	a_not_ready_off: assert property (s_not_ready |-> !on) else $error("gate on not ready");
	a_limit_off: assert property ($rose(limit_trip) |-> ##[0:3] !on) else $error("limit late");
	a_limit_flag: assert property ($rose(limit_trip) && on |-> ##[1:5] current_limit_flag)
		else $error("flag not raised");
	a_reset_flag: assert property ($rose(rst_n) |-> current_limit_flag) else $error("flag low");
	a_pwm_ends: assert property ($rose(pwm_trip) ##1 pwm_trip |-> ##[0:2] !on) else $error("pwm late");
	a_gate_from_rise: assert property ($rose(on) |-> $past(pulse_train, 3) || $past(pulse_train, 4))
		else $error("gate without pulse");
endmodule : pwm_gate_sva
`default_nettype wire

// [tb/push_pull_pwm_gate_logic_bench.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin fails++; $display("MISMATCH %0t %s", $time, m); end end
module push_pull_pwm_gate_logic_bench;
	logic clk_sys = 0, rst_n = 0, ref_good = 0, supplies_good = 0, pwm_trip = 0;
	logic limit_trip = 0, run_enable = 0, calm = 1, running;
	logic [15:0] period_cycles = 16'h0020, duty_limit = 16'h0010;
	logic [1:0] limit_policy = 2'h0, gate_drive_output;
	logic [7:0] limit_events;
	logic flag_q[$];
	int fails = 0, num_checks = 0, cycles = 0;
	pwm_gate_if link_if();
	push_pull_pwm_gate_logic push_pull_pwm_gate_logic_i (.clk_sys(clk_sys), .rst_n(rst_n),
		.link(link_if), .ref_good(ref_good), .supplies_good(supplies_good), .pwm_trip(pwm_trip),
		.limit_trip(limit_trip), .gate_drive_output(gate_drive_output));
	pwm_pulse_controller pwm_pulse_controller_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(link_if),
		.run_enable(run_enable), .period_cycles(period_cycles), .duty_limit(duty_limit),
		.limit_policy(limit_policy), .limit_events(limit_events), .running(running));
	pwm_gate_sva pwm_gate_sva_i (.clk_sys(clk_sys), .rst_n(rst_n), .pulse_train(link_if.pulse_train),
		.current_limit_flag(link_if.current_limit_flag), .ref_good(ref_good),
		.supplies_good(supplies_good), .pwm_trip(pwm_trip), .limit_trip(limit_trip),
		.gate_drive_output(gate_drive_output));
	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		pwm_trip <= !calm && (|gate_drive_output) && ($urandom % 16 == 0);
		if (cycles == 20000) begin
			fails++;
			end_of_test();
		end
	end
	always @(link_if.current_limit_flag) if (rst_n) begin
		`CHK(link_if.current_limit_flag, flag_q.size() ? flag_q.pop_front() : 1'bx, "flag edge")
	end
	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test
	initial begin
		void'($urandom(32'hE60AC723));
		for (int p = 0; p < 4; p++) begin
			rst_n <= 0;
			ref_good <= 0;
			supplies_good <= 0;
			calm <= 1;
			run_enable <= 1;
			limit_policy <= p[1:0];
			period_cycles <= 16'h0020 + 16'($urandom % 32);
			duty_limit <= 16'h000C + 16'($urandom % 8);
			repeat (2) @(posedge clk_sys);
			rst_n <= 1;
			repeat (20) @(posedge clk_sys);
			`CHK(gate_drive_output, 2'h0, "gate while not ready")
			`CHK(link_if.current_limit_flag, 1'b1, "flag while not ready")
			flag_q.push_back(1'b0);
			ref_good <= 1;
			supplies_good <= 1;
			for (int n = 0; n < 3000 && !(|gate_drive_output); n++) @(posedge clk_sys);
			`CHK(|gate_drive_output, 1'b1, "no gate pulse")
			repeat (1000) @(posedge clk_sys);
			for (int n = 0; n < 200 && !(|gate_drive_output); n++) @(posedge clk_sys);
			flag_q.push_back(1'b1);
			limit_trip <= 1;
			repeat (2) @(posedge clk_sys);
			limit_trip <= 0;
			calm <= 0;
			if (p > 1)
				flag_q.push_back(1'b0);
			repeat (600) @(posedge clk_sys);
			`CHK(limit_events, 8'h01, "limit event count")
			`CHK(flag_q.size(), 0, "flag edges missing")
			$display("test policy %0d done", p);
		end
		run_enable <= 0;
		repeat (200) @(posedge clk_sys);
		`CHK(gate_drive_output, 2'h0, "gate without pulses")
		$display("test idle done");
		end_of_test();
	end
endmodule : push_pull_pwm_gate_logic_bench
`default_nettype wire
